// >>> rtl/axis_ref_pkg.sv
// Package: shared types and constants of the axis referencing sequencer
package axis_ref_pkg;
  localparam int POS_W = 32;
  localparam int VEL_W = 16;
  // Adjustment command state codes
  localparam logic [2:0] ADJ_IDLE = 3'h0;
  localparam logic [2:0] ADJ_VALID = 3'h3;
  localparam logic [2:0] ADJ_ACCEPT = 3'h4;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADJ_OFFSET = 8'h08;
  localparam logic [7:0] OFF_ADJ_CMD = 8'h0C;
  localparam logic [7:0] OFF_CAM_VEL = 8'h10;
  localparam logic [7:0] OFF_MAX_ACC = 8'h14;
  localparam logic [7:0] OFF_MAX_DEC = 8'h18;
  localparam logic [7:0] OFF_CAM_DIST = 8'h1C;
  localparam logic [7:0] OFF_REF_COORD = 8'h20;
  localparam logic [7:0] OFF_ENC_POS = 8'h24;
  localparam logic [7:0] OFF_ACT_POS = 8'h28;
  // Control register fields
  localparam int CTRL_CAM_PRESENT = 0;
  localparam int CTRL_EDS_CHANGE = 1;
  localparam int CTRL_CLR_FAULT = 2;
  localparam int CTRL_CLR_NOTE = 3;
  // Status register fields
  localparam int ST_REF_SET = 0;
  localparam int ST_SAVE_NOTE = 1;
  localparam int ST_WRONG_DIR = 2;
  localparam int ST_CAM_MISSING = 3;
  localparam int ST_ACTIVE = 4;
  localparam int ST_SYNC = 5;
  localparam int ST_LIMIT_OFF = 6;
  localparam int ST_OVR_EN = 7;
  // Reset values
  localparam logic [VEL_W-1:0] CAM_VEL_RST = 16'h0100;
  localparam logic [VEL_W-1:0] ACC_RST = 16'h0010;
  localparam logic [POS_W-1:0] CAM_DIST_RST = 32'h0010_0000;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CAM_SEARCH, SEQ_CAM_BRAKE, SEQ_ZERO_SYNC, SEQ_ABORT_STOP
  } seq_state_e;

  // Motion command to the trajectory stage
  typedef struct packed {
    logic active;
    logic dir_neg;
    logic brake;
    logic [VEL_W-1:0] target_vel;
    logic [VEL_W-1:0] ramp;
  } motion_cmd_s;
endpackage

// >>> rtl/zero_mark_edge.sv
// Zero mark edge selector: direction dependent edge detect
`timescale 1ns/1ps
`default_nettype none
module zero_mark_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised mark and travel direction
  input wire logic mark_i,
  input wire logic pos_increasing_i,
  // Detected edge
  output logic hit_o
);
  logic mark_d_r;
  wire rise = mark_i & ~mark_d_r;
  wire fall = ~mark_i & mark_d_r;
  // No inversion option on the encoder mark
  wire hit_nxt = pos_increasing_i ? rise : fall;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mark_d_r <= 1'b0;
      hit_o <= 1'b0;
    end else begin
      mark_d_r <= mark_i;
      hit_o <= hit_nxt;
    end
  end
endmodule // zero_mark_edge
`default_nettype wire

// >>> rtl/axis_referencing_sequencer.sv
// Axis referencing sequencer: offset adjustment and cam search
// What this block does
// - Adjustment command 4 computes position from offset, reports 3, sets reference flag.
// - Accepted offset acts at once, no restart needed.
// - Identified adjustment raises a save-to-nonvolatile note.
// - Offset held in retained register across reset; actual position and reference flag reset to 0.
// - Incremental encoder switch-on sets non-referenced position to 0.
// - Start input with cam present and type 0 begins cam travel.
// - Start must stay asserted; early drop aborts referencing.
// - Starting an approach clears the reference flag.
// - Limit switches off during approach; only traversing range checked.
// - Velocity override applies only during cam search.
// - Without cam, zero-mark sync starts directly.
// - Cam search at max acceleration; direction input 0 means positive.
// - Cam reached: one cycle of braking at max deceleration, then zero-mark sync without waiting for standstill.
// - Either reversing cam reverses search direction.
// - Reversing cam hit from wrong direction raises a fault.
// - Reversing cams active low; both active keeps axis still during cam search.
// - Cam found starts zero-mark sync after the one brake cycle.
// - Max cam distance exceeded stops axis, raises cam-not-found fault.
// - Already on cam at start skips straight to sync.
// - Encoder data set change clears reference flag.
// - Zero mark rising edge when increasing, falling when decreasing.
// - At reference point load positions with coordinate unless an offset was accepted since reset, then set flag.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module axis_referencing_sequencer #(
  parameter int POS_W = axis_ref_pkg::POS_W,
  parameter int VEL_W = axis_ref_pkg::VEL_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Controller and switch pins
  input wire logic referencing_start_input_i,
  input wire logic referencing_type_select_i,
  input wire logic start_direction_input_i,
  input wire logic reference_cam_input_i,
  input wire logic reversing_cam_minus_input_n_i,
  input wire logic reversing_cam_plus_input_n_i,
  input wire logic zero_mark_i,
  input wire logic at_standstill_i,
  input wire logic ref_point_reached_i,
  // Position feedback and override
  input wire logic [POS_W-1:0] axis_pos_i,
  input wire logic [7:0] velocity_override_i,
  // Outputs
  output axis_ref_pkg::motion_cmd_s motion_o,
  output logic reference_point_set_flag_o,
  output logic sw_limit_enable_o,
  output logic zero_sync_active_o,
  output logic zero_mark_hit_o,
  output logic wrong_dir_fault_o,
  output logic cam_missing_fault_o,
  output logic save_note_o
);
  // ==========================================================
  // Pin synchronisers (two flops before any logic)
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] s1_r, s2_r;
  wire [NSYNC-1:0] pins = {zero_mark_i, reversing_cam_plus_input_n_i,
    reversing_cam_minus_input_n_i, reference_cam_input_i, start_direction_input_i,
    referencing_type_select_i, referencing_start_input_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle pin levels: reversing cams released, so no false edge after reset
      s1_r <= 7'h30;
      s2_r <= 7'h30;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire start_s = s2_r[0];
  wire type_s = s2_r[1];
  wire dir_s = s2_r[2];
  wire cam_s = s2_r[3];
  wire rev_minus = ~s2_r[4];
  wire rev_plus = ~s2_r[5];
  wire mark_s = s2_r[6];

  // ==========================================================
  // Registers
  logic cam_present_r;
  logic [POS_W-1:0] adj_offset_r;
  logic [2:0] adj_cmd_r;
  logic [VEL_W-1:0] cam_vel_r, acc_r, dec_r;
  logic [POS_W-1:0] cam_dist_r, ref_coord_r, act_pos_r, ref_shift_r;
  logic ref_set_r, note_r, wrong_r, missing_r;
  logic abs_mode_r;

  wire wb_req = cyc_i & stb_i & ~ack_o;
  // Writes land on the edge where the master sees ack, address still held
  wire wb_wr = cyc_i & stb_i & ack_o & we_i;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire wr_ctrl = wb_wr & (adr_i == axis_ref_pkg::OFF_CTRL);
  wire wr_off = wb_wr & (adr_i == axis_ref_pkg::OFF_ADJ_OFFSET);
  wire wr_cmd = wb_wr & (adr_i == axis_ref_pkg::OFF_ADJ_CMD) & sel_i[0];
  wire wr_vel = wb_wr & (adr_i == axis_ref_pkg::OFF_CAM_VEL);
  wire wr_acc = wb_wr & (adr_i == axis_ref_pkg::OFF_MAX_ACC);
  wire wr_dec = wb_wr & (adr_i == axis_ref_pkg::OFF_MAX_DEC);
  wire wr_dist = wb_wr & (adr_i == axis_ref_pkg::OFF_CAM_DIST);
  wire wr_coord = wb_wr & (adr_i == axis_ref_pkg::OFF_REF_COORD);
  wire [31:0] ctrl_w = dat_i & wmask;
  wire eds_change = wr_ctrl & ctrl_w[axis_ref_pkg::CTRL_EDS_CHANGE];
  wire clr_fault = wr_ctrl & ctrl_w[axis_ref_pkg::CTRL_CLR_FAULT];
  wire clr_note = wr_ctrl & ctrl_w[axis_ref_pkg::CTRL_CLR_NOTE];
  wire adj_accept = wr_cmd & (dat_i[2:0] == axis_ref_pkg::ADJ_ACCEPT);

  // ==========================================================
  // Sequencer
  axis_ref_pkg::seq_state_e state_r, state_nxt;
  logic dir_neg_r;
  logic [POS_W-1:0] start_pos_r;
  wire start_ok = start_s & ~type_s;
  logic start_d_r;
  wire start_edge = start_ok & ~start_d_r;
  wire idle = (state_r == axis_ref_pkg::SEQ_IDLE);
  wire busy = ~idle & (state_r != axis_ref_pkg::SEQ_ABORT_STOP);
  wire launch = idle & start_edge;
  // Distance either way from the start, so a turn at a reversing cam keeps counting
  wire [POS_W-1:0] pos_diff = POS_W'(axis_pos_i - start_pos_r);
  wire [POS_W-1:0] travelled = pos_diff[POS_W-1] ? POS_W'(start_pos_r - axis_pos_i) : pos_diff;
  wire search = (state_r == axis_ref_pkg::SEQ_CAM_SEARCH);
  wire both_rev = rev_minus & rev_plus;
  logic rev_minus_d_r, rev_plus_d_r;
  // Act on a cam becoming active; standing on it after the turn is no fault
  wire rev_minus_e = rev_minus & ~rev_minus_d_r;
  wire rev_plus_e = rev_plus & ~rev_plus_d_r;
  wire wrong_hit = search & ~both_rev &
    ((rev_minus_e & ~dir_neg_r) | (rev_plus_e & dir_neg_r));
  wire rev_hit = search & (rev_minus_e | rev_plus_e) & ~both_rev;
  wire dist_over = search & (travelled >= cam_dist_r);
  wire zm_hit;
  wire ref_done = (state_r == axis_ref_pkg::SEQ_ZERO_SYNC) &
    (state_nxt == axis_ref_pkg::SEQ_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      axis_ref_pkg::SEQ_IDLE: begin
        if (launch) begin
          if (!cam_present_r || cam_s) state_nxt = axis_ref_pkg::SEQ_ZERO_SYNC;
          else state_nxt = axis_ref_pkg::SEQ_CAM_SEARCH;
        end
      end
      axis_ref_pkg::SEQ_CAM_SEARCH: begin
        if (!start_ok || dist_over || wrong_hit) state_nxt = axis_ref_pkg::SEQ_ABORT_STOP;
        else if (cam_s) state_nxt = axis_ref_pkg::SEQ_CAM_BRAKE;
      end
      axis_ref_pkg::SEQ_CAM_BRAKE: begin
        if (!start_ok) state_nxt = axis_ref_pkg::SEQ_ABORT_STOP;
        else state_nxt = axis_ref_pkg::SEQ_ZERO_SYNC;
      end
      axis_ref_pkg::SEQ_ZERO_SYNC: begin
        if (!start_ok) state_nxt = axis_ref_pkg::SEQ_ABORT_STOP;
        else if (ref_point_reached_i) state_nxt = axis_ref_pkg::SEQ_IDLE;
      end
      axis_ref_pkg::SEQ_ABORT_STOP: begin
        if (at_standstill_i) state_nxt = axis_ref_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Motion command
  wire [VEL_W+7:0] ovr_prod = cam_vel_r * velocity_override_i;
  // Override only while searching so cam end and mark are crossed alike
  wire [VEL_W-1:0] search_vel = ovr_prod[VEL_W+6:7];
  axis_ref_pkg::motion_cmd_s motion_nxt;
  always_comb begin
    motion_nxt = '0;
    motion_nxt.dir_neg = dir_neg_r;
    if (search && !both_rev) begin
      motion_nxt.active = 1'b1;
      motion_nxt.target_vel = search_vel;
      motion_nxt.ramp = acc_r;
    end else if (state_r == axis_ref_pkg::SEQ_ZERO_SYNC) begin
      motion_nxt.active = 1'b1;
      motion_nxt.target_vel = cam_vel_r;
      motion_nxt.ramp = acc_r;
    end else if (!idle) begin
      motion_nxt.active = 1'b1;
      motion_nxt.brake = 1'b1;
      motion_nxt.ramp = dec_r;
    end
  end

  zero_mark_edge u_zm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mark_i(mark_s),
    .pos_increasing_i(~dir_neg_r),
    .hit_o(zm_hit)
  );

  // ==========================================================
  // Sequencer and flag registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= axis_ref_pkg::SEQ_IDLE;
      dir_neg_r <= 1'b0;
      start_pos_r <= '0;
      start_d_r <= 1'b0;
      motion_o <= '0;
      ref_set_r <= 1'b0;
      wrong_r <= 1'b0;
      missing_r <= 1'b0;
      note_r <= 1'b0;
      adj_cmd_r <= axis_ref_pkg::ADJ_IDLE;
      act_pos_r <= '0;
      abs_mode_r <= 1'b0;
      ref_shift_r <= '0;
      rev_minus_d_r <= 1'b0;
      rev_plus_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rev_minus_d_r <= rev_minus;
      rev_plus_d_r <= rev_plus;
      start_d_r <= start_ok;
      motion_o <= motion_nxt;
      if (launch) begin
        dir_neg_r <= dir_s;
        start_pos_r <= axis_pos_i;
      end else if (rev_hit && !wrong_hit) begin
        dir_neg_r <= ~dir_neg_r;
      end
      // Fault flags: set wins over clear
      wrong_r <= wrong_hit | (wrong_r & ~clr_fault);
      missing_r <= dist_over | (missing_r & ~clr_fault);
      note_r <= adj_accept | (note_r & ~clr_note);
      if (adj_accept) begin
        adj_cmd_r <= axis_ref_pkg::ADJ_VALID;
        abs_mode_r <= 1'b1;
      end else if (wr_cmd) begin
        adj_cmd_r <= dat_i[2:0];
      end
      // Reference flag
      if (adj_accept) ref_set_r <= 1'b1;
      else if (launch || eds_change) ref_set_r <= 1'b0;
      else if (ref_done) ref_set_r <= 1'b1;
      // Actual position; encoder plus offset once an offset is accepted, else after referencing it follows the encoder from the coordinate
      if (abs_mode_r || adj_accept) begin
        act_pos_r <= POS_W'(axis_pos_i + adj_offset_r);
      end else if (ref_done) begin
        act_pos_r <= ref_coord_r;
        ref_shift_r <= POS_W'(ref_coord_r - axis_pos_i);
      end else if (ref_set_r) begin
        act_pos_r <= POS_W'(axis_pos_i + ref_shift_r);
      end
    end
  end

  // Offset kept in retained storage; reset does not touch it
  always_ff @(posedge clk_i) begin
    if (wr_off) adj_offset_r <= (adj_offset_r & ~wmask) | (dat_i & wmask);
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cam_present_r <= 1'b1;
      cam_vel_r <= axis_ref_pkg::CAM_VEL_RST;
      acc_r <= axis_ref_pkg::ACC_RST;
      dec_r <= axis_ref_pkg::ACC_RST;
      cam_dist_r <= axis_ref_pkg::CAM_DIST_RST;
      ref_coord_r <= '0;
    end else begin
      if (wr_ctrl && sel_i[0]) cam_present_r <= dat_i[axis_ref_pkg::CTRL_CAM_PRESENT];
      if (wr_vel) cam_vel_r <= VEL_W'(dat_i & wmask);
      if (wr_acc) acc_r <= VEL_W'(dat_i & wmask);
      if (wr_dec) dec_r <= VEL_W'(dat_i & wmask);
      if (wr_dist) cam_dist_r <= (cam_dist_r & ~wmask) | (dat_i & wmask);
      if (wr_coord) ref_coord_r <= (ref_coord_r & ~wmask) | (dat_i & wmask);
    end
  end

  // ==========================================================
  // Read mux and ack
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[axis_ref_pkg::ST_REF_SET] = ref_set_r;
    status_w[axis_ref_pkg::ST_SAVE_NOTE] = note_r;
    status_w[axis_ref_pkg::ST_WRONG_DIR] = wrong_r;
    status_w[axis_ref_pkg::ST_CAM_MISSING] = missing_r;
    status_w[axis_ref_pkg::ST_ACTIVE] = busy;
    status_w[axis_ref_pkg::ST_SYNC] = (state_r == axis_ref_pkg::SEQ_ZERO_SYNC);
    status_w[axis_ref_pkg::ST_LIMIT_OFF] = busy;
    status_w[axis_ref_pkg::ST_OVR_EN] = search;
  end
  logic [31:0] rd_w;
  always_comb begin
    unique case (adr_i)
      axis_ref_pkg::OFF_CTRL: rd_w = {31'h0, cam_present_r};
      axis_ref_pkg::OFF_STATUS: rd_w = status_w;
      axis_ref_pkg::OFF_ADJ_OFFSET: rd_w = adj_offset_r;
      axis_ref_pkg::OFF_ADJ_CMD: rd_w = {29'h0, adj_cmd_r};
      axis_ref_pkg::OFF_CAM_VEL: rd_w = {16'h0, cam_vel_r};
      axis_ref_pkg::OFF_MAX_ACC: rd_w = {16'h0, acc_r};
      axis_ref_pkg::OFF_MAX_DEC: rd_w = {16'h0, dec_r};
      axis_ref_pkg::OFF_CAM_DIST: rd_w = cam_dist_r;
      axis_ref_pkg::OFF_REF_COORD: rd_w = ref_coord_r;
      axis_ref_pkg::OFF_ENC_POS: rd_w = axis_pos_i;
      axis_ref_pkg::OFF_ACT_POS: rd_w = act_pos_r;
      default: rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      reference_point_set_flag_o <= 1'b0;
      sw_limit_enable_o <= 1'b1;
      zero_sync_active_o <= 1'b0;
      zero_mark_hit_o <= 1'b0;
      wrong_dir_fault_o <= 1'b0;
      cam_missing_fault_o <= 1'b0;
      save_note_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
      dat_o <= wb_req ? rd_w : 32'h0;
      reference_point_set_flag_o <= ref_set_r;
      sw_limit_enable_o <= ~busy;
      zero_sync_active_o <= (state_r == axis_ref_pkg::SEQ_ZERO_SYNC);
      zero_mark_hit_o <= zm_hit & (state_r == axis_ref_pkg::SEQ_ZERO_SYNC);
      wrong_dir_fault_o <= wrong_r;
      cam_missing_fault_o <= missing_r;
      save_note_o <= note_r;
    end
  end
endmodule // axis_referencing_sequencer
`default_nettype wire

// >>> verification/axis_referencing_sequencer_checker.sv
// Checker: port assertions of the axis referencing sequencer
`timescale 1ns/1ps
`default_nettype none
module axis_ref_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Pins and results
  input wire logic referencing_start_input_i,
  input wire logic reversing_cam_minus_input_n_i,
  input wire logic reversing_cam_plus_input_n_i,
  input wire logic zero_mark_i,
  input wire axis_ref_pkg::motion_cmd_s motion_o,
  input wire logic reference_point_set_flag_o,
  input wire logic sw_limit_enable_o,
  input wire logic zero_sync_active_o,
  input wire logic zero_mark_hit_o,
  input wire logic wrong_dir_fault_o,
  input wire logic cam_missing_fault_o,
  input wire logic save_note_o
);
  // ============================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr_ok = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  wire logic halted = !motion_o.active || motion_o.brake;
  // Sync must have settled before an edge counts, the pins lag two flops
  sequence s_sync_hold;
    zero_sync_active_o [*3];
  endsequence
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_adj_accept;
    wr_ok && adr_i == axis_ref_pkg::OFF_ADJ_CMD && dat_i[2:0] == axis_ref_pkg::ADJ_ACCEPT
      |-> ##[1:2] (reference_point_set_flag_o && save_note_o);
  endproperty
  a_adj_accept: assert property (p_adj_accept) else $error("offset accept failed");
  property p_eds_clear;
    wr_ok && adr_i == axis_ref_pkg::OFF_CTRL && dat_i[axis_ref_pkg::CTRL_EDS_CHANGE]
      |-> ##[1:2] !reference_point_set_flag_o;
  endproperty
  a_eds_clear: assert property (p_eds_clear) else $error("flag kept on data set change");
  property p_start_clear;
    $fell(sw_limit_enable_o) |-> ##[0:2] !reference_point_set_flag_o;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("flag kept at start");
  property p_abort;
    !referencing_start_input_i [*6] |-> sw_limit_enable_o && !zero_sync_active_o;
  endproperty
  a_abort: assert property (p_abort) else $error("start drop not aborted");
  property p_both_rev;
    (!reversing_cam_minus_input_n_i && !reversing_cam_plus_input_n_i) [*6]
      ##0 !zero_sync_active_o |-> halted;
  endproperty
  a_both_rev: assert property (p_both_rev) else $error("axis moves on both cams");
  property p_sync_vel;
    s_sync_hold |-> $stable(motion_o.target_vel);
  endproperty
  a_sync_vel: assert property (p_sync_vel) else $error("sync speed changed");
  property p_mark_edge;
    s_sync_hold ##0 (motion_o.dir_neg ? $fell(zero_mark_i) : $rose(zero_mark_i))
      |-> ##[1:5] zero_mark_hit_o;
  endproperty
  a_mark_edge: assert property (p_mark_edge) else $error("zero mark edge missed");
  property p_fault_stop;
    $rose(wrong_dir_fault_o || cam_missing_fault_o) |-> ##[0:6] halted;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault without stop");
endmodule // axis_ref_checker
bind axis_referencing_sequencer axis_ref_checker u_axis_ref_checker (.*);
`default_nettype wire

// >>> verification/axis_motion_model.sv
// Partner: motion stage with a reference cam switch
`timescale 1ns/1ps
`default_nettype none
module axis_motion_model #(
  parameter int CAM_LO = 40,
  parameter int CAM_HI = 60
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command in, feedback out
  input wire axis_ref_pkg::motion_cmd_s motion_i,
  output logic [31:0] pos_o,
  output logic standstill_o,
  output logic cam_o
);
  // ============================================================
  // One count per cycle; braking stops at once, no overshoot
  wire logic moving = motion_i.active && !motion_i.brake && (motion_i.target_vel != 16'h0);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o <= 32'h0;
    end else if (moving) begin
      pos_o <= motion_i.dir_neg ? pos_o - 32'h1 : pos_o + 32'h1;
    end
  end
  assign standstill_o = !moving;
  // Finite window, so each pass gives a rising and a falling edge
  assign cam_o = ($signed(pos_o) >= CAM_LO) && ($signed(pos_o) < CAM_HI);
endmodule // axis_motion_model
`default_nettype wire

// >>> verification/axis_referencing_sequencer_tb_top.sv
// Testbench: bus and pin scenarios for the axis referencing sequencer
`timescale 1ns/1ps
`default_nettype none
module axis_referencing_sequencer_tb_top;
  // ============================================================
  // Signals and instances
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, pos, q, p_ref;
  logic start, typ, dir, rev_m_n, rev_p_n, zmark, reached, stand, cam;
  logic flag, lim, sync, hit, wrong, miss, note;
  axis_ref_pkg::motion_cmd_s mo;
  int num_errors, checks;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h30};
  logic [31:0] rv [9] = '{32'h1, 32'h0, 32'h100, 32'h10, 32'h10, 32'h100000, 32'h0, 32'h0,
    32'h0};
  axis_referencing_sequencer u_axis_referencing_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .referencing_start_input_i(start), .referencing_type_select_i(typ),
    .start_direction_input_i(dir), .reference_cam_input_i(cam),
    .reversing_cam_minus_input_n_i(rev_m_n), .reversing_cam_plus_input_n_i(rev_p_n),
    .zero_mark_i(zmark), .at_standstill_i(stand), .ref_point_reached_i(reached),
    .axis_pos_i(pos), .velocity_override_i(8'h40), .motion_o(mo),
    .reference_point_set_flag_o(flag), .sw_limit_enable_o(lim), .zero_sync_active_o(sync),
    .zero_mark_hit_o(hit), .wrong_dir_fault_o(wrong), .cam_missing_fault_o(miss),
    .save_note_o(note));
  axis_motion_model u_axis_motion_model (.clk_i(clk_i), .rst_i(rst_i), .motion_i(mo),
    .pos_o(pos), .standstill_o(stand), .cam_o(cam));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is seen, read data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: sig = mo.active;
      1: sig = sync;
      2: sig = flag;
      3: sig = wrong;
      4: sig = miss;
      default: sig = hit;
    endcase
  endfunction
  task automatic wait_on(input int k, input int lim_n);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < lim_n) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(sig(k)), 32'h1);
  endtask
  task automatic do_rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic go(input logic d);
    @(posedge clk_i);
    start <= 1'b1;
    dir <= d;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
  // ============================================================
  // Scenarios
  initial begin
    {rst_i, cyc_i, stb_i, we_i, start, typ, dir, zmark, reached} = '0;
    {adr_i, dat_i, sel_i, rev_m_n, rev_p_n} = {8'h0, 32'h0, 4'hF, 2'b11};
    rst_i = 1'b1;
    do_rst();
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    xfer(1'b1, 8'h08, 32'h100);
    xfer(1'b1, 8'h0C, 32'h4);
    rd(8'h0C, 32'h3);
    rd(8'h04, 32'h3);
    rd(8'h28, 32'h100);
    xfer(1'b1, 8'h00, 32'hB);
    rd(8'h04, 32'h0);
    do_rst();
    rd(8'h08, 32'h100);
    xfer(1'b1, 8'h20, 32'h55);
    go(1'b0);
    wait_on(0, 20);
    chk(32'(mo.dir_neg), 32'h0);
    chk(32'(mo.ramp), 32'(axis_ref_pkg::ACC_RST));
    chk(32'(mo.target_vel), 32'h80);
    chk(32'(lim), 32'h0);
    wait_on(1, 400);
    chk(32'(mo.target_vel), 32'(axis_ref_pkg::CAM_VEL_RST));
    chk(32'(flag), 32'h0);
    repeat (2) @(posedge clk_i);
    zmark <= 1'b1;
    if (mo.dir_neg === 1'b1) begin
      repeat (6) @(posedge clk_i);
      zmark <= 1'b0;
    end
    wait_on(5, 10);
    reached <= 1'b1;
    @(posedge clk_i);
    p_ref = pos;
    reached <= 1'b0;
    wait_on(2, 20);
    xfer(1'b0, 8'h24, 32'h0);
    rd(8'h28, 32'h55 + q - p_ref);
    start <= 1'b0;
    do_rst();
    xfer(1'b1, 8'h1C, 32'h14);
    go(1'b0);
    wait_on(4, 100);
    repeat (6) @(posedge clk_i);
    chk(32'(mo.active & !mo.brake), 32'h0);
    rd(8'h04, 32'h8);
    start <= 1'b0;
    do_rst();
    go(1'b0);
    wait_on(0, 20);
    rev_p_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    rev_p_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(mo.dir_neg), 32'h1);
    rev_p_n <= 1'b0;
    wait_on(3, 20);
    rev_p_n <= 1'b1;
    start <= 1'b0;
    xfer(1'b1, 8'h00, 32'h5);
    {rev_m_n, rev_p_n} <= 2'b00;
    go(1'b0);
    repeat (10) @(posedge clk_i);
    chk(32'(mo.active & !mo.brake), 32'h0);
    {rev_m_n, rev_p_n} <= 2'b11;
    repeat (4) @(posedge clk_i);
    chk(32'(mo.active & !mo.brake), 32'h1);
    start <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(mo.active & !mo.brake), 32'h0);
    chk(32'(lim), 32'h1);
    rd(8'h04, 32'h0);
    typ <= 1'b1;
    go(1'b0);
    repeat (8) @(posedge clk_i);
    chk(32'(lim), 32'h1);
    start <= 1'b0;
    typ <= 1'b0;
    xfer(1'b1, 8'h00, 32'h0);
    go(1'b1);
    wait_on(1, 10);
    repeat (2) @(posedge clk_i);
    zmark <= 1'b0;
    wait_on(5, 10);
    start <= 1'b0;
    repeat (8) @(posedge clk_i);
    complete_run();
  end
endmodule // axis_referencing_sequencer_tb_top
`default_nettype wire
